// >>> hdl/fp_class_pkg.sv
// Constants and types shared by the operand classifier files
package fp_class_pkg;

  // ----------------------------------------------------------------
  // Format geometry
  // ----------------------------------------------------------------
  localparam int SGL_EXP_W   = 8;
  localparam int SGL_FRAC_W  = 23;
  localparam int DBL_EXP_W   = 11;
  localparam int DBL_FRAC_W  = 52;
  localparam int DBL_SIGN_POS = 63;
  localparam int DBL_EXP_LSB = 52;
  localparam int SGL_SIGN_POS = 31;
  localparam int SGL_EXP_LSB = 23;
  localparam int WORD_W      = 64;

  // ----------------------------------------------------------------
  // Biases and exponent range
  // ----------------------------------------------------------------
  localparam logic [10:0] SGL_BIAS = 11'h07f;   // 127
  localparam logic [10:0] DBL_BIAS = 11'h3ff;   // 1023
  localparam logic signed [12:0] SGL_EMIN = -13'sd126;
  localparam logic signed [12:0] DBL_EMIN = -13'sd1022;

  // ----------------------------------------------------------------
  // Special encodings
  // ----------------------------------------------------------------
  localparam logic [63:0] SGL_DEFAULT_QNAN = 64'h0000_0000_7fbf_ffff;
  localparam logic [63:0] DBL_DEFAULT_QNAN = 64'h7ff7_ffff_ffff_ffff;
  localparam logic [63:0] SGL_POS_INF      = 64'h0000_0000_7f80_0000;
  localparam logic [63:0] SGL_NEG_INF      = 64'h0000_0000_ff80_0000;
  localparam logic [63:0] DBL_POS_INF      = 64'h7ff0_0000_0000_0000;
  localparam logic [63:0] DBL_NEG_INF      = 64'hfff0_0000_0000_0000;

  // ----------------------------------------------------------------
  // Reset values and class codes (one-hot)
  // ----------------------------------------------------------------
  localparam int CLASS_W = 6;
  localparam logic [5:0] CLS_ZERO = 6'h01;
  localparam logic [5:0] CLS_DEN  = 6'h02;
  localparam logic [5:0] CLS_NORM = 6'h04;
  localparam logic [5:0] CLS_INF  = 6'h08;
  localparam logic [5:0] CLS_QNAN = 6'h10;
  localparam logic [5:0] CLS_SNAN = 6'h20;
  localparam logic [5:0] CLASS_RST = 6'h01;

  // Operation requested of the special-case logic
  typedef enum logic [2:0] {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_MUL = 3'h2,
    OP_DIV = 3'h3,
    OP_CMP = 3'h4
  } fp_op_t;

endpackage

// >>> hdl/fp_operand_classifier.sv
// Operand classifier with default results for special operands
// Notes on behaviour
// - Single word is 1 sign bit, 8 exponent bits, 23 fraction bits.
// - Double word: sign bit 63, exponent 62..52, fraction 51..0.
// - Stored exponent equals true exponent plus 127 or 1023 bias.
// - Exponent within the normal range means normalized, hidden bit one.
// - Zero exponent with nonzero fraction is denormal, hidden bit zero.
// - Zero exponent and zero fraction is a signed zero, never denormal.
// - All-ones exponent with zero fraction is signed infinity.
// - All-ones exponent, nonzero fraction is NaN; top fraction bit signals.
// - Each nonzero value has one encoding; normalized where possible.
// - Division by zero yields a correctly signed infinity.
// - Minus infinity orders below all finite values, plus above.
// - Meaningful arithmetic on infinities is exact, raising nothing.
// - Meaningless arithmetic on infinities raises invalid operation.
// - Untrapped exceptions complete with an infinity or NaN result.
// - Default infinities remain usable operands later on.
// - Signaling NaN operand raises invalid; never produced as result.
// - Quiet NaN raises nothing; result copies an operand quiet NaN.
// - Fresh quiet NaN is 0x7fbfffff single, 0x7ff7ffffffffffff double.
`timescale 1ns/1ps
`default_nettype none
module fp_operand_classifier
  import fp_class_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         in_valid,
  input  wire logic                         is_dbl,
  input  wire fp_class_pkg::fp_op_t         op,
  input  wire logic [fp_class_pkg::WORD_W-1:0] opa,
  input  wire logic [fp_class_pkg::WORD_W-1:0] opb,
  output logic                              out_valid,
  output logic [fp_class_pkg::CLASS_W-1:0]  class_a,
  output logic [fp_class_pkg::CLASS_W-1:0]  class_b,
  output logic                              sign_a,
  output logic                              sign_b,
  output logic                              hidden_a,
  output logic                              hidden_b,
  output logic signed [12:0]                uexp_a,
  output logic                              special,
  output logic [fp_class_pkg::WORD_W-1:0]   default_result,
  output logic                              flag_invalid,
  output logic                              flag_div_zero,
  output logic                              cmp_less,
  output logic                              cmp_equal,
  output logic                              cmp_unordered
);
  import fp_class_pkg::*;

  // ----------------------------------------------------------------
  // Operand decoders
  // ----------------------------------------------------------------
  logic                sa, sb, ha, hb;
  logic signed [12:0]  ua;
  logic [CLASS_W-1:0]  ca, cb;

  // Both operands share one format, stated by the issuer
  fp_operand_decode u_dec_a (
    .word   (opa),
    .is_dbl (is_dbl),
    .sign   (sa),
    .bexp   (),
    .frac   (),
    .uexp   (ua),
    .hidden (ha),
    .cls    (ca)
  );

  fp_operand_decode u_dec_b (
    .word   (opb),
    .is_dbl (is_dbl),
    .sign   (sb),
    .bexp   (),
    .frac   (),
    .uexp   (),
    .hidden (hb),
    .cls    (cb)
  );

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Signed infinity for the current format
  function automatic logic [63:0] inf_of(input logic dbl, input logic s);
    if (dbl)
      inf_of = s ? DBL_NEG_INF : DBL_POS_INF;
    else
      inf_of = s ? SGL_NEG_INF : SGL_POS_INF;
  endfunction

  // Word with its NaN made quiet (top fraction bit cleared)
  function automatic logic [63:0] quieten(input logic dbl,
                                          input logic [63:0] w);
    logic [63:0] r;
    r = w;
    if (dbl)
      r[DBL_FRAC_W-1] = 1'b0;
    else
      r[SGL_FRAC_W-1] = 1'b0;
    quieten = dbl ? r : {32'h0, r[31:0]};
  endfunction

  // Unsigned key from the sign-magnitude word that orders like the encoded value
  function automatic logic [63:0] order_key(input logic dbl,
                                            input logic [63:0] w);
    logic [63:0] m;
    m = dbl ? w : {w[31:0], 32'h0};
    order_key = m[63] ? ~m : {1'b1, m[62:0]};
  endfunction

  // ----------------------------------------------------------------
  // Special-case and ordering decisions
  // ----------------------------------------------------------------
  logic              nan_a, nan_b, snan_any, qnan_a, qnan_b;
  logic              inf_a, inf_b, zero_a, zero_b;
  logic              special_d, inv_d, dz_d, lt_d, eq_d, un_d;
  logic [63:0]       res_d;
  logic [63:0]       key_a, key_b;
  logic              sx;

  always_comb begin
    qnan_a   = (ca == CLS_QNAN);
    qnan_b   = (cb == CLS_QNAN);
    nan_a    = qnan_a || (ca == CLS_SNAN);
    nan_b    = qnan_b || (cb == CLS_SNAN);
    snan_any = (ca == CLS_SNAN) || (cb == CLS_SNAN);
    inf_a    = (ca == CLS_INF);
    inf_b    = (cb == CLS_INF);
    zero_a   = (ca == CLS_ZERO);
    zero_b   = (cb == CLS_ZERO);
    sx       = sa ^ sb;
    key_a    = order_key(is_dbl, opa);
    key_b    = order_key(is_dbl, opb);
    special_d = 1'b0;
    inv_d     = 1'b0;
    dz_d      = 1'b0;
    res_d     = 64'h0;
    // NaN operands take priority over every other case
    if (snan_any) begin
      special_d = 1'b1;
      inv_d     = 1'b1;
      // Never pass a signaling NaN on: copy a quiet one or make one
      if (qnan_a)
        res_d = quieten(is_dbl, opa);
      else if (qnan_b)
        res_d = quieten(is_dbl, opb);
      else
        res_d = is_dbl ? DBL_DEFAULT_QNAN : SGL_DEFAULT_QNAN;
    end else if (nan_a || nan_b) begin
      special_d = 1'b1;
      res_d = qnan_a ? quieten(is_dbl, opa) : quieten(is_dbl, opb);
    end else begin
      case (op)
        OP_ADD, OP_SUB: begin
          if (inf_a && inf_b && ((op == OP_ADD) == sx)) begin
            special_d = 1'b1;
            inv_d     = 1'b1;
            res_d = is_dbl ? DBL_DEFAULT_QNAN : SGL_DEFAULT_QNAN;
          end else if (inf_a) begin
            special_d = 1'b1;
            res_d = inf_of(is_dbl, sa);
          end else if (inf_b) begin
            special_d = 1'b1;
            res_d = inf_of(is_dbl, sb ^ (op == OP_SUB));
          end
        end
        OP_MUL: begin
          if ((inf_a && zero_b) || (zero_a && inf_b)) begin
            special_d = 1'b1;
            inv_d     = 1'b1;
            res_d = is_dbl ? DBL_DEFAULT_QNAN : SGL_DEFAULT_QNAN;
          end else if (inf_a || inf_b) begin
            special_d = 1'b1;
            res_d = inf_of(is_dbl, sx);
          end
        end
        OP_DIV: begin
          if ((inf_a && inf_b) || (zero_a && zero_b)) begin
            special_d = 1'b1;
            inv_d     = 1'b1;
            res_d = is_dbl ? DBL_DEFAULT_QNAN : SGL_DEFAULT_QNAN;
          end else if (inf_a) begin
            special_d = 1'b1;
            res_d = inf_of(is_dbl, sx);
          end else if (zero_b) begin
            special_d = 1'b1;
            dz_d      = 1'b1;
            res_d = inf_of(is_dbl, sx);
          end else if (inf_b) begin
            special_d = 1'b1;
            res_d = is_dbl ? {sx, 63'h0} : {32'h0, sx, 31'h0};
          end
        end
        default: begin
          special_d = 1'b0;
        end
      endcase
    end
    // Ordering: infinities bound the finite range; zeros compare equal
    un_d = nan_a || nan_b;
    eq_d = !un_d && ((zero_a && zero_b) || (key_a == key_b));
    lt_d = !un_d && !eq_d && (key_a < key_b);
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  logic                out_valid_q;
  logic [CLASS_W-1:0]  class_a_q, class_b_q;
  logic                sign_a_q, sign_b_q, hidden_a_q, hidden_b_q;
  logic signed [12:0]  uexp_a_q;
  logic                special_q, inv_q, dz_q, lt_q, eq_q, un_q;
  logic [63:0]         res_q;

  // Result registers load on each valid operand pair
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      class_a_q   <= CLASS_RST;
      class_b_q   <= CLASS_RST;
      sign_a_q    <= 1'b0;
      sign_b_q    <= 1'b0;
      hidden_a_q  <= 1'b0;
      hidden_b_q  <= 1'b0;
      uexp_a_q    <= 13'sh0;
      special_q   <= 1'b0;
      inv_q       <= 1'b0;
      dz_q        <= 1'b0;
      lt_q        <= 1'b0;
      eq_q        <= 1'b0;
      un_q        <= 1'b0;
      res_q       <= 64'h0;
    end else begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        class_a_q  <= ca;
        class_b_q  <= cb;
        sign_a_q   <= sa;
        sign_b_q   <= sb;
        hidden_a_q <= ha;
        hidden_b_q <= hb;
        uexp_a_q   <= (ca == CLS_DEN) ?
                      (is_dbl ? DBL_EMIN : SGL_EMIN) : ua;
        special_q  <= special_d;
        inv_q      <= inv_d;
        dz_q       <= dz_d;
        lt_q       <= lt_d;
        eq_q       <= eq_d;
        un_q       <= un_d;
        res_q      <= res_d;
      end
    end
  end

  assign out_valid      = out_valid_q;
  assign class_a        = class_a_q;
  assign class_b        = class_b_q;
  assign sign_a         = sign_a_q;
  assign sign_b         = sign_b_q;
  assign hidden_a       = hidden_a_q;
  assign hidden_b       = hidden_b_q;
  assign uexp_a         = uexp_a_q;
  assign special        = special_q;
  assign default_result = res_q;
  assign flag_invalid   = inv_q;
  assign flag_div_zero  = dz_q;
  assign cmp_less       = lt_q;
  assign cmp_equal      = eq_q;
  assign cmp_unordered  = un_q;

endmodule
`default_nettype wire

// >>> hdl/fp_operand_decode.sv
// Combinational split and classification of one operand
`timescale 1ns/1ps
`default_nettype none
module fp_operand_decode
  import fp_class_pkg::*;
(
  input  wire logic [fp_class_pkg::WORD_W-1:0]  word,
  input  wire logic                             is_dbl,
  output logic                                  sign,
  output logic [10:0]                           bexp,
  output logic [51:0]                           frac,
  output logic signed [12:0]                    uexp,
  output logic                                  hidden,
  output logic [fp_class_pkg::CLASS_W-1:0]      cls
);

  // ----------------------------------------------------------------
  // Field split and class decode
  // ----------------------------------------------------------------
  logic exp_zero;
  logic exp_ones;
  logic frac_zero;
  logic top_frac;

  // Field extraction by format
  always_comb begin
    if (is_dbl) begin
      sign = word[DBL_SIGN_POS];
      bexp = word[DBL_SIGN_POS-1:DBL_EXP_LSB];
      frac = word[DBL_FRAC_W-1:0];
      exp_ones = &word[DBL_SIGN_POS-1:DBL_EXP_LSB];
      top_frac = word[DBL_FRAC_W-1];
      uexp = $signed({2'b00, bexp}) - $signed({2'b00, DBL_BIAS});
    end else begin
      sign = word[SGL_SIGN_POS];
      bexp = {3'h0, word[SGL_SIGN_POS-1:SGL_EXP_LSB]};
      frac = {29'h0, word[SGL_FRAC_W-1:0]};
      exp_ones = &word[SGL_SIGN_POS-1:SGL_EXP_LSB];
      top_frac = word[SGL_FRAC_W-1];
      uexp = $signed({2'b00, bexp}) - $signed({2'b00, SGL_BIAS});
    end
    exp_zero  = (bexp == 11'h000);
    frac_zero = (frac == 52'h0);
    // Hidden bit is one only for normalized encodings
    hidden = !exp_zero && !exp_ones;
    if (exp_zero && frac_zero)
      cls = CLS_ZERO;
    else if (exp_zero)
      cls = CLS_DEN;
    else if (exp_ones && frac_zero)
      cls = CLS_INF;
    else if (exp_ones && top_frac)
      cls = CLS_SNAN;
    else if (exp_ones)
      cls = CLS_QNAN;
    else
      cls = CLS_NORM;
  end

endmodule
`default_nettype wire

// >>> verif/fp_class_monitor.sv
// Concurrent checks on the operand classifier ports
`timescale 1ns/1ps
`default_nettype none
module fp_class_monitor
  import fp_class_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset,
  input wire logic                  in_valid,
  input wire logic                  is_dbl,
  input wire fp_class_pkg::fp_op_t  op,
  input wire logic [63:0]           opa,
  input wire logic [63:0]           opb,
  input wire logic                  out_valid,
  input wire logic [5:0]            class_a,
  input wire logic [5:0]            class_b,
  input wire logic                  sign_a,
  input wire logic                  sign_b,
  input wire logic                  hidden_a,
  input wire logic                  hidden_b,
  input wire logic signed [12:0]    uexp_a,
  input wire logic                  special,
  input wire logic [63:0]           default_result,
  input wire logic                  flag_invalid,
  input wire logic                  flag_div_zero,
  input wire logic                  cmp_less,
  input wire logic                  cmp_equal,
  input wire logic                  cmp_unordered
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Handshake and class coding
  // ----------------------------------------------------------------
  valid_lat_a: assert property (in_valid |=> out_valid)
    else $error("result strobe missing after a request");
  valid_once_a: assert property (!in_valid |=> !out_valid)
    else $error("result strobe without a request");
  class_onehot_a: assert property (
    out_valid |-> $onehot(class_a) && $onehot(class_b))
    else $error("class outputs not one-hot");
  hidden_norm_a: assert property (
    out_valid |-> hidden_a == (class_a == CLS_NORM)
    && hidden_b == (class_b == CLS_NORM))
    else $error("hidden bit disagrees with class");

  // ----------------------------------------------------------------
  // Field decoding
  // ----------------------------------------------------------------
  zero_sign_a: assert property (
    in_valid && !is_dbl && opa[30:0] == 31'h0
    |=> class_a == CLS_ZERO && sign_a == $past(opa[31]))
    else $error("single zero misclassified");
  inf_class_a: assert property (
    in_valid && !is_dbl && opa[30:0] == 31'h7f800000
    |=> class_a == CLS_INF)
    else $error("single infinity misclassified");
  nan_kind_a: assert property (
    in_valid && is_dbl && opa[62:52] == 11'h7ff && opa[51:0] != 52'h0
    |=> class_a == ($past(opa[51]) ? CLS_SNAN : CLS_QNAN))
    else $error("double NaN kind wrong");
  dbl_denorm_a: assert property (
    in_valid && is_dbl && opa[62:52] == 11'h0 && opa[51:0] != 52'h0
    |=> class_a == CLS_DEN && uexp_a == DBL_EMIN)
    else $error("double denormal misclassified");
  sgl_bias_a: assert property (
    in_valid && !is_dbl && opa[30:23] != 8'h00 && opa[30:23] != 8'hff
    |=> uexp_a == $signed({5'h00, $past(opa[30:23])}) - 13'sd127)
    else $error("single exponent bias wrong");
  no_snan_out_a: assert property (
    out_valid && special && !$past(is_dbl)
    |-> !(default_result[30:23] == 8'hff && default_result[22]))
    else $error("signaling NaN delivered as result");
endmodule

bind fp_operand_classifier fp_class_monitor fp_class_monitor_i (
  .clk(clk), .reset(reset), .in_valid(in_valid), .is_dbl(is_dbl),
  .op(op), .opa(opa), .opb(opb), .out_valid(out_valid),
  .class_a(class_a), .class_b(class_b), .sign_a(sign_a), .sign_b(sign_b),
  .hidden_a(hidden_a), .hidden_b(hidden_b), .uexp_a(uexp_a),
  .special(special), .default_result(default_result),
  .flag_invalid(flag_invalid), .flag_div_zero(flag_div_zero),
  .cmp_less(cmp_less), .cmp_equal(cmp_equal), .cmp_unordered(cmp_unordered)
);
`default_nettype wire

// >>> verif/fp_issue_model.sv
// Issuing pipeline model that presents operands to the classifier
`timescale 1ns/1ps
`default_nettype none
module fp_issue_model
  import fp_class_pkg::*;
(
  input  wire logic             clk,
  output logic                  in_valid,
  output fp_class_pkg::fp_op_t  op,
  output logic                  is_dbl,
  output logic [63:0]           opa,
  output logic [63:0]           opb
);
  // Idle values at time zero
  initial begin
    in_valid = 1'b0;
    op = OP_ADD;
    is_dbl = 1'b0;
    opa = 64'h0;
    opb = 64'h0;
  end

  // One request held for exactly one taking edge
  task automatic send(input fp_op_t o, input logic d, input logic [63:0] a,
                      input logic [63:0] b);
    @(posedge clk);
    #1;
    in_valid = 1'b1;
    op = o;
    is_dbl = d;
    opa = a;
    opb = b;
    @(posedge clk);
    #1;
    in_valid = 1'b0;
    opa = ~a; // Released operands stop showing the old value
    opb = ~b;
  endtask
endmodule
`default_nettype wire

// >>> verif/fp_operand_format_classifier_bench.sv
// Self-checking bench for the operand classifier
`timescale 1ns/1ps
`default_nettype none
module fp_operand_format_classifier_bench;
  import fp_class_pkg::*;
  logic clk, reset, in_valid, is_dbl, out_valid, sign_a, sign_b;
  logic hidden_a, hidden_b, special, flag_invalid, flag_div_zero;
  logic cmp_less, cmp_equal, cmp_unordered;
  logic [5:0] class_a, class_b;
  logic signed [12:0] uexp_a;
  logic [63:0] opa, opb, default_result, ra, rb;
  fp_op_t op;
  int mismatches = 0;
  int checks_done = 0;
  logic [31:0] lfsr_q = 32'h0000_0042;
  logic [63:0] tbl [12] = '{64'h00800000, 64'h007fffff, 64'h80000000,
    64'h7f7fffff, 64'h7fbfffff, 64'h7fc00000, 64'hff800000, 64'h00000001,
    64'h0010000000000000, 64'h000fffffffffffff, 64'h8000000000000000,
    64'h7ff8000000000000};
  localparam logic [63:0] S_INF  = 64'h7f800000;
  localparam logic [63:0] S_ONE  = 64'h3f800000;
  localparam logic [63:0] S_QNEW = 64'h7fbfffff;
  localparam logic [63:0] S_SNAN = 64'h7fffffff;
  localparam logic [63:0] S_QNAN = 64'h7fa00001;

  // ----------------------------------------------------------------
  // Clock, design and issuing model
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #4 clk = ~clk;

  fp_operand_classifier fp_operand_classifier_i (.clk(clk), .reset(reset),
    .in_valid(in_valid), .is_dbl(is_dbl), .op(op), .opa(opa), .opb(opb),
    .out_valid(out_valid), .class_a(class_a), .class_b(class_b),
    .sign_a(sign_a), .sign_b(sign_b), .hidden_a(hidden_a),
    .hidden_b(hidden_b), .uexp_a(uexp_a), .special(special),
    .default_result(default_result), .flag_invalid(flag_invalid),
    .flag_div_zero(flag_div_zero), .cmp_less(cmp_less),
    .cmp_equal(cmp_equal), .cmp_unordered(cmp_unordered));
  fp_issue_model fp_issue_model_i (.clk(clk), .in_valid(in_valid), .op(op),
    .is_dbl(is_dbl), .opa(opa), .opb(opb));

  // ----------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] ref_class(logic [63:0] w, logic d);
    int e;
    logic [51:0] f;
    e = d ? int'(w[62:52]) : int'(w[30:23]);
    f = d ? w[51:0] : {29'h0, w[22:0]};
    if (e == 0) return (f == 0) ? CLS_ZERO : CLS_DEN;
    if (e == (d ? 2047 : 255))
      return (f == 0) ? CLS_INF : ((d ? w[51] : w[22]) ? CLS_SNAN : CLS_QNAN);
    return CLS_NORM;
  endfunction

  function automatic int ref_uexp(logic [63:0] w, logic d);
    int e;
    int bias;
    e = d ? int'(w[62:52]) : int'(w[30:23]);
    bias = d ? 1023 : 127;
    if (e != 0) return e - bias;
    return (ref_class(w, d) == CLS_ZERO) ? -bias : 1 - bias;
  endfunction

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Two LFSR steps make one 64-bit random operand
  function automatic logic [63:0] rnd();
    logic [63:0] v;
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : 32'h0);
    v[31:0] = lfsr_q;
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h0040_0007 : 32'h0);
    v[63:32] = lfsr_q;
    return v;
  endfunction

  // Classify a pair and compare every per-operand output, uexp_a only when a is zero, denormal or normalized
  task automatic run_class(input logic d, input logic [63:0] a, b);
    logic [5:0] ca;
    ca = ref_class(a, d);
    fp_issue_model_i.send(OP_CMP, d, a, b);
    check("out_valid", out_valid, 64'h1);
    check("class_a", class_a, ca);
    check("class_b", class_b, ref_class(b, d));
    check("sign_a", sign_a, d ? a[63] : a[31]);
    check("sign_b", sign_b, d ? b[63] : b[31]);
    check("hidden_a", hidden_a, ca == CLS_NORM);
    check("hidden_b", hidden_b, ref_class(b, d) == CLS_NORM);
    if (ca == CLS_ZERO || ca == CLS_DEN || ca == CLS_NORM)
      check("uexp_a", 64'(uexp_a), 64'(ref_uexp(a, d)));
  endtask

  // Special operand case with its default result and flags
  task automatic run_spec(input fp_op_t o, input logic d,
    input logic [63:0] a, b, res, input logic inv, dz);
    fp_issue_model_i.send(o, d, a, b);
    check("special", special, 64'h1);
    check("default_result", default_result, res);
    check("flag_invalid", flag_invalid, inv);
    check("flag_div_zero", flag_div_zero, dz);
  endtask

  task automatic run_cmp(input logic [63:0] a, b, input logic lt, eq, un);
    fp_issue_model_i.send(OP_CMP, 1'b0, a, b);
    check("cmp_less", cmp_less, lt);
    check("cmp_equal", cmp_equal, eq);
    check("cmp_unordered", cmp_unordered, un);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #(8 * 20000);
    mismatches++;
    end_sim();
  end

  initial begin
    reset = 1'b1;
    repeat (16) @(posedge clk);
    check("reset class_a", class_a, CLASS_RST);
    check("reset out_valid", out_valid, 64'h0);
    #1;
    reset = 1'b0;
    for (int i = 0; i < 12; i++)
      run_class(i >= 8, tbl[i], tbl[(i + 1) % 12]);
    $display("boundary classes done");
    run_spec(OP_DIV, 0, S_INF, 64'h0, S_INF, 0, 0);
    run_spec(OP_DIV, 0, S_ONE, 64'h0, S_INF, 0, 1);
    run_spec(OP_DIV, 0, 64'hbf800000, 64'h0, 64'hff800000, 0, 1);
    run_spec(OP_ADD, 0, S_INF, S_ONE, S_INF, 0, 0);
    run_spec(OP_SUB, 0, S_INF, S_INF, S_QNEW, 1, 0);
    run_spec(OP_MUL, 0, 64'h0, 64'hff800000, S_QNEW, 1, 0);
    run_spec(OP_DIV, 0, 64'h0, 64'h80000000, S_QNEW, 1, 0);
    run_spec(OP_DIV, 0, S_ONE, 64'hff800000, 64'h80000000, 0, 0);
    run_spec(OP_SUB, 1, DBL_POS_INF, DBL_POS_INF,
             DBL_DEFAULT_QNAN, 1, 0);
    run_spec(OP_ADD, 0, S_SNAN, S_ONE, S_QNEW, 1, 0);
    run_spec(OP_ADD, 0, S_ONE, S_QNAN, S_QNAN, 0, 0);
    run_spec(OP_ADD, 0, S_QNAN, S_SNAN, S_QNAN, 1, 0);
    $display("special results done");
    run_cmp(64'hff800000, 64'h7f7fffff, 1, 0, 0);
    run_cmp(64'h7f7fffff, 64'h7f800000, 1, 0, 0);
    run_cmp(64'h7f800000, 64'hff7fffff, 0, 0, 0);
    run_cmp(64'h00000000, 64'h80000000, 0, 1, 0);
    run_cmp(S_QNAN, S_ONE, 0, 0, 1);
    $display("ordering done");
    for (int i = 0; i < 200; i++) begin
      ra = rnd();
      rb = rnd();
      run_class(lfsr_q[5], ra, rb);
    end
    $display("random classes done");
    end_sim();
  end
endmodule
`default_nettype wire
